// ==== hw/sapll_pkg.sv ====
package sapll_pkg;

    // ************************************************************
    // Register map (byte offsets, byte address = word index * 4)
    // ************************************************************
    localparam logic [7:0] SAPLL_REG_CTRL   = 8'h00;
    localparam logic [7:0] SAPLL_REG_FBDIV  = 8'h04;
    localparam logic [7:0] SAPLL_REG_FNUM_L = 8'h08;
    localparam logic [7:0] SAPLL_REG_FNUM_H = 8'h0C;
    localparam logic [7:0] SAPLL_REG_FDEN   = 8'h10;
    localparam logic [7:0] SAPLL_REG_STAT   = 8'h14;
    localparam logic [7:0] SAPLL_REG_IRQ_ST = 8'h18;
    localparam logic [7:0] SAPLL_REG_IRQ_MK = 8'h1C;
    localparam logic [7:0] SAPLL_REG_ID     = 8'h20;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SAPLL_CTRL_DBL_BIT   = 0;
    localparam int SAPLL_CTRL_GPIO_BIT  = 1;
    localparam int SAPLL_STAT_LOCK_BIT  = 0;
    localparam int SAPLL_STAT_LOL_BIT   = 1;
    localparam int SAPLL_STAT_DONE_BIT  = 2;
    localparam int SAPLL_STAT_SRC_LSB   = 3;
    localparam int SAPLL_STAT_BADW_BIT  = 5;
    localparam int SAPLL_EV_LOL_BIT     = 0;
    localparam int SAPLL_EV_LOCK_BIT    = 1;
    localparam int SAPLL_EV_BADDIV_BIT  = 2;
    localparam int SAPLL_EV_LOADED_BIT  = 3;

    // ************************************************************
    // Widths, limits and reset values
    // ************************************************************
    localparam int SAPLL_NUM_W   = 48;
    localparam int SAPLL_DEN_W   = 16;
    localparam int SAPLL_FBDIV_W = 10;
    localparam int SAPLL_VC_W    = 12;
    localparam int SAPLL_EV_N    = 4;
    localparam logic [9:0]  SAPLL_FBDIV_MIN = 10'h07A;
    localparam logic [9:0]  SAPLL_FBDIV_MAX = 10'h230;
    localparam logic [9:0]  SAPLL_FBDIV_RST = 10'h07A;
    localparam logic [15:0] SAPLL_DEN_RST   = 16'h0001;
    localparam logic [31:0] SAPLL_ID_RST    = 32'h0000_5A01;
    // Lock window half-width in control-level codes
    localparam logic [11:0] SAPLL_LOCK_TOL  = 12'h040;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SAPLL_CLK_MHZ      = 25;
    localparam int SAPLL_LOCK_US      = 2;
    localparam int SAPLL_LOCK_CYCLES  = SAPLL_LOCK_US * SAPLL_CLK_MHZ;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SAPLL_SRC_NONE   = 2'h0,
        SAPLL_SRC_OTP    = 2'h1,
        SAPLL_SRC_EEPROM = 2'h2
    } sapll_src_t;

    typedef struct packed {
        logic                     doubler;
        logic [SAPLL_FBDIV_W-1:0] fbdiv;
        logic [SAPLL_NUM_W-1:0]   freq_num;
        logic [SAPLL_DEN_W-1:0]   freq_den;
    } sapll_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } sapll_bus_t;

endpackage

// ==== hw/sapll_lock_det.sv ====
`timescale 1ns/1ps
module sapll_lock_det
    import sapll_pkg::*;
#(
    parameter int LOCK_CYCLES = SAPLL_LOCK_CYCLES
) (
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     restart_i,
    input  wire logic [SAPLL_VC_W-1:0]    vctrl_i,
    input  wire logic [SAPLL_VC_W-1:0]    lo_lim_i,
    input  wire logic [SAPLL_VC_W-1:0]    hi_lim_i,
    output logic                          locked_o
);
    localparam int CW = $clog2(LOCK_CYCLES + 1);

    logic [CW-1:0] cnt_r;
    logic          locked_r;
    wire           in_win = (vctrl_i >= lo_lim_i) && (vctrl_i <= hi_lim_i);
    wire           full   = (cnt_r == CW'(LOCK_CYCLES));

    // Level must stay in window for a full qualifying time before lock
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r    <= '0;
            locked_r <= 1'b0;
        end else if (restart_i || !in_win) begin
            cnt_r    <= '0;
            locked_r <= 1'b0;
        end else if (!full) begin
            cnt_r    <= cnt_r + CW'(1);
        end else begin
            locked_r <= 1'b1;
        end
    end

    assign locked_o = locked_r;
endmodule // sapll_lock_det

// ==== hw/sapll_top.sv ====
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Frequency values held as 48-bit numerator over 16-bit denominator.
// - Control bit selects crystal directly or through the doubler.
// - Feedback divider accepts only integers 122 to 560 inclusive.
// - At reset, load settings from valid enabled OTP or EEPROM.
// - After load completes, host may rewrite configuration at any time.
// - Lock means control level inside limits derived from the configuration; the code also requires the resynchronised raw lock sense to be high.
// - Loss-of-lock alarm readable in status and routable to a GPIO.
// - Crystal-driven PLL is origin of all internal clocks.
// - Register locations fixed across all family variants.
module sapll_top
    import sapll_pkg::*;
#(
    parameter int                 LOCK_CYCLES = SAPLL_LOCK_CYCLES,
    parameter logic [31:0]        ID_VALUE    = SAPLL_ID_RST  // Arbitrary value
) (
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    input  wire logic [7:0]               addr_i,
    input  wire logic [31:0]              wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic [31:0]                   rdata_o,
    input  wire logic                     otp_en_i,
    input  wire logic                     otp_valid_i,
    input  wire sapll_pkg::sapll_cfg_t    otp_cfg_i,
    input  wire logic                     eep_en_i,
    input  wire logic                     eep_valid_i,
    input  wire logic                     eep_done_i,
    input  wire sapll_pkg::sapll_cfg_t    eep_cfg_i,
    input  wire logic                     pll_lock_raw_i,
    input  wire logic [SAPLL_VC_W-1:0]    vctrl_i,
    output sapll_pkg::sapll_cfg_t         cfg_o,
    output logic                          ref_doubler_o,
    output logic                          cfg_done_o,
    output logic                          locked_o,
    output logic                          lol_alarm_o,
    output logic                          gpio_lol_o,
    output logic                          irq_o
);
    import sapll_pkg::*;

    // ************************************************************
    // Reset-time load sequencer
    // ************************************************************
    typedef enum logic [2:0] {
        SAPLL_ST_IDLE = 3'b001,
        SAPLL_ST_WAIT = 3'b010,
        SAPLL_ST_RUN  = 3'b100
    } sapll_st_t;

    sapll_st_t   st_r, st_nxt;
    sapll_src_t  src_r, src_nxt;
    sapll_cfg_t  cfg_r, cfg_nxt;
    logic        gpio_en_r;
    logic        badw_r;
    logic [SAPLL_EV_N-1:0] ev_st_r, ev_mk_r, ev_set;
    logic [31:0] rdata_r;
    logic        lol_s1_r, lol_s2_r, lol_q_r;
    logic        locked_det;

    function automatic logic fbdiv_ok(input logic [SAPLL_FBDIV_W-1:0] v);
        fbdiv_ok = (v >= SAPLL_FBDIV_MIN) && (v <= SAPLL_FBDIV_MAX);
    endfunction

    wire use_otp = otp_en_i && otp_valid_i && fbdiv_ok(otp_cfg_i.fbdiv);
    wire use_eep = eep_en_i && eep_valid_i && fbdiv_ok(eep_cfg_i.fbdiv);

    always_comb begin
        st_nxt  = st_r;
        src_nxt = src_r;
        case (st_r)
            SAPLL_ST_IDLE: begin
                if (use_otp) begin
                    src_nxt = SAPLL_SRC_OTP;
                    st_nxt  = SAPLL_ST_RUN;
                end else if (eep_en_i) begin
                    st_nxt  = SAPLL_ST_WAIT;
                end else begin
                    src_nxt = SAPLL_SRC_NONE;
                    st_nxt  = SAPLL_ST_RUN;
                end
            end
            SAPLL_ST_WAIT: begin
                // No timeout: an EEPROM that never finishes holds the block here
                if (eep_done_i) begin
                    src_nxt = use_eep ? SAPLL_SRC_EEPROM : SAPLL_SRC_NONE;
                    st_nxt  = SAPLL_ST_RUN;
                end
            end
            SAPLL_ST_RUN: st_nxt = SAPLL_ST_RUN;
            default:      st_nxt = SAPLL_ST_IDLE;
        endcase
    end

    wire running   = (st_r == SAPLL_ST_RUN);
    wire load_now  = (st_r != SAPLL_ST_RUN) && (st_nxt == SAPLL_ST_RUN);

    // ************************************************************
    // Register write decode
    // ************************************************************
    // host writes only after the load completes
    wire wr_ok     = wr_i && running;
    // fixed offsets, same on every variant
    wire wr_ctrl   = wr_ok && (addr_i == SAPLL_REG_CTRL);
    wire wr_fbdiv  = wr_ok && (addr_i == SAPLL_REG_FBDIV);
    wire wr_numl   = wr_ok && (addr_i == SAPLL_REG_FNUM_L);
    wire wr_numh   = wr_ok && (addr_i == SAPLL_REG_FNUM_H);
    wire wr_den    = wr_ok && (addr_i == SAPLL_REG_FDEN);
    wire wr_irqst  = wr_ok && (addr_i == SAPLL_REG_IRQ_ST);
    wire wr_irqmk  = wr_ok && (addr_i == SAPLL_REG_IRQ_MK);
    wire fb_in_rng = fbdiv_ok(wdata_i[SAPLL_FBDIV_W-1:0]);
    wire fb_bad    = wr_fbdiv && !fb_in_rng;

    always_comb begin
        cfg_nxt = cfg_r;
        if (load_now && use_otp) begin
            cfg_nxt = otp_cfg_i;
        end else if (load_now && (st_r == SAPLL_ST_WAIT) && use_eep) begin
            cfg_nxt = eep_cfg_i;
        end
        if (wr_ctrl) begin
            cfg_nxt.doubler = wdata_i[SAPLL_CTRL_DBL_BIT];
        end
        if (wr_fbdiv && fb_in_rng) begin
            cfg_nxt.fbdiv = wdata_i[SAPLL_FBDIV_W-1:0];
        end
        if (wr_numl) begin
            cfg_nxt.freq_num[31:0] = wdata_i;
        end
        if (wr_numh) begin
            cfg_nxt.freq_num[SAPLL_NUM_W-1:32] = wdata_i[15:0];
        end
        if (wr_den) begin
            cfg_nxt.freq_den = wdata_i[SAPLL_DEN_W-1:0];
        end
    end

    // ************************************************************
    // State and configuration registers
    // ************************************************************
    // every register runs on the one crystal-derived clock
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r     <= SAPLL_ST_IDLE;
            src_r    <= SAPLL_SRC_NONE;
            cfg_r    <= '{doubler: 1'b0, fbdiv: SAPLL_FBDIV_RST,
                          freq_num: '0, freq_den: SAPLL_DEN_RST};
        end else begin
            st_r     <= st_nxt;
            src_r    <= src_nxt;
            cfg_r    <= cfg_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gpio_en_r <= 1'b0;
            badw_r    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                gpio_en_r <= wdata_i[SAPLL_CTRL_GPIO_BIT];
            end
            if (wr_fbdiv) begin
                badw_r <= fb_bad;
            end
        end
    end

    // ************************************************************
    // Lock detection
    // ************************************************************
    // window centred on a level derived from divider and doubler
    wire [SAPLL_VC_W-1:0] vc_centre = SAPLL_VC_W'({cfg_r.fbdiv, 1'b0})
                                      + SAPLL_VC_W'(cfg_r.doubler);
    wire [SAPLL_VC_W-1:0] lo_lim    = (vc_centre > SAPLL_LOCK_TOL) ?
                                      vc_centre - SAPLL_LOCK_TOL : '0;
    wire [SAPLL_VC_W-1:0] hi_lim    = vc_centre + SAPLL_LOCK_TOL;
    wire                  reconfig  = wr_ctrl || (wr_fbdiv && fb_in_rng) || load_now;

    sapll_lock_det #(
        .LOCK_CYCLES (LOCK_CYCLES)
    ) u_lock (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .restart_i   (reconfig || !running),
        .vctrl_i     (vctrl_i),
        .lo_lim_i    (lo_lim),
        .hi_lim_i    (hi_lim),
        .locked_o    (locked_det)
    );

    // Reset to unlocked so the alarm stands until lock is proven
    // unlock raw sense resynchronised; alarm whenever unlocked
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lol_s1_r <= 1'b1;
            lol_s2_r <= 1'b1;
            lol_q_r  <= 1'b1;
        end else begin
            lol_s1_r <= !pll_lock_raw_i;
            lol_s2_r <= lol_s1_r;
            lol_q_r  <= lol_s2_r || !locked_det;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic lol_d_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lol_d_r <= 1'b1;
        end else begin
            lol_d_r <= lol_q_r;
        end
    end

    assign ev_set[SAPLL_EV_LOL_BIT]    = lol_q_r && !lol_d_r;
    assign ev_set[SAPLL_EV_LOCK_BIT]   = !lol_q_r && lol_d_r;
    assign ev_set[SAPLL_EV_BADDIV_BIT] = fb_bad;
    assign ev_set[SAPLL_EV_LOADED_BIT] = load_now;

    // Set wins over write-one-to-clear
    wire [SAPLL_EV_N-1:0] ev_clr = wr_irqst ? wdata_i[SAPLL_EV_N-1:0] : '0;

    // Per-bit sticky status
    for (genvar gi = 0; gi < SAPLL_EV_N; gi++) begin : g_ev_st
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                ev_st_r[gi] <= 1'b0;
            end else if (ev_set[gi]) begin
                ev_st_r[gi] <= 1'b1;
            end else if (ev_clr[gi]) begin
                ev_st_r[gi] <= 1'b0;
            end
        end
    end

    // Mask register, same layout as status
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ev_mk_r <= '0;
        end else if (wr_irqmk) begin
            ev_mk_r <= wdata_i[SAPLL_EV_N-1:0];
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_i)
            SAPLL_REG_CTRL:   rd_mux = {30'h0, gpio_en_r, cfg_r.doubler};
            SAPLL_REG_FBDIV:  rd_mux = {22'h0, cfg_r.fbdiv};
            SAPLL_REG_FNUM_L: rd_mux = cfg_r.freq_num[31:0];
            SAPLL_REG_FNUM_H: rd_mux = {16'h0, cfg_r.freq_num[SAPLL_NUM_W-1:32]};
            SAPLL_REG_FDEN:   rd_mux = {16'h0, cfg_r.freq_den};
            SAPLL_REG_STAT:   rd_mux = {26'h0, badw_r, src_r, running,
                                        lol_q_r, !lol_q_r};
            SAPLL_REG_IRQ_ST: rd_mux = {28'h0, ev_st_r};
            SAPLL_REG_IRQ_MK: rd_mux = {28'h0, ev_mk_r};
            SAPLL_REG_ID:     rd_mux = ID_VALUE;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // Zero outside the answer cycle, so a stale word is never taken
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdata_o       = rdata_r;
    assign cfg_o         = cfg_r;
    assign ref_doubler_o = cfg_r.doubler;
    assign cfg_done_o    = running;
    assign locked_o      = !lol_q_r;
    assign lol_alarm_o   = lol_q_r;
    assign gpio_lol_o    = gpio_en_r & lol_q_r;
    assign irq_o         = |(ev_st_r & ev_mk_r);
endmodule // sapll_top

// ==== dv/sapll_checker.sv ====
`timescale 1ns/1ps
module sapll_checker
    import sapll_pkg::*;
#(
    parameter int          LOCK_CYCLES = 4,
    parameter logic [31:0] ID_VALUE    = 32'h0
) (
    input wire logic                  clk_i,
    input wire logic                  resetn_i,
    input wire logic [7:0]            addr_i,
    input wire logic                  wr_i,
    input wire logic                  rd_i,
    input wire logic [31:0]           rdata_o,
    input wire logic                  pll_lock_raw_i,
    input wire logic [SAPLL_VC_W-1:0] vctrl_i,
    input wire sapll_pkg::sapll_cfg_t cfg_o,
    input wire logic                  ref_doubler_o,
    input wire logic                  cfg_done_o,
    input wire logic                  locked_o,
    input wire logic                  lol_alarm_o,
    input wire logic                  gpio_lol_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    int lo_w;
    int run_r;
    logic in_w;
    assign lo_w = 2 * int'(cfg_o.fbdiv) + int'(cfg_o.doubler) - 64;
    assign in_w = pll_lock_raw_i && int'(vctrl_i) >= lo_w && int'(vctrl_i) <= lo_w + 128;
    // Length of the current run of lockable cycles; the lock sync only lengthens it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            run_r <= 0;
        else if (in_w)
            run_r <= run_r + 1;
        else
            run_r <= 0;
    end
    sequence id_read_s;
        rd_i && addr_i == SAPLL_REG_ID;
    endsequence
    sequence early_wr_s;
        (!cfg_done_o && wr_i) ##1 !cfg_done_o;
    endsequence
    lol_mirror_a: assert property (lol_alarm_o == !locked_o)
        else $error("alarm does not mirror lock");
    gpio_route_a: assert property (gpio_lol_o |-> lol_alarm_o)
        else $error("pin alarm without alarm");
    dbl_follow_a: assert property (ref_doubler_o == cfg_o.doubler)
        else $error("doubler select differs from config");
    fbdiv_range_a: assert property (cfg_done_o |-> cfg_o.fbdiv inside {[SAPLL_FBDIV_MIN:SAPLL_FBDIV_MAX]})
        else $error("divider out of range");
    id_fixed_a: assert property (id_read_s |=> rdata_o == ID_VALUE)
        else $error("identity read wrong");
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data outside read cycle");
    done_hold_a: assert property (cfg_done_o |=> cfg_done_o)
        else $error("load done dropped");
    early_wr_a: assert property (early_wr_s |-> $stable(cfg_o))
        else $error("write before load took effect");
    lock_qual_a: assert property ($rose(locked_o) |-> run_r >= LOCK_CYCLES - 1)
        else $error("lock without qualifying run");
    raw_drop_a: assert property (!pll_lock_raw_i [*5] |-> !locked_o)
        else $error("lock kept without raw lock");
endmodule // sapll_checker

bind sapll_top sapll_checker #(.LOCK_CYCLES(LOCK_CYCLES), .ID_VALUE(ID_VALUE)) chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pll_lock_raw_i(pll_lock_raw_i), .vctrl_i(vctrl_i), .cfg_o(cfg_o),
    .ref_doubler_o(ref_doubler_o), .cfg_done_o(cfg_done_o), .locked_o(locked_o),
    .lol_alarm_o(lol_alarm_o), .gpio_lol_o(gpio_lol_o));

// ==== dv/sapll_eep_model.sv ====
`timescale 1ns/1ps
module sapll_eep_model
    import sapll_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic [7:0]            delay_i,
    input  wire logic                  good_i,
    input  wire sapll_pkg::sapll_cfg_t image_i,
    output logic                       eep_valid_o,
    output logic                       eep_done_o,
    output sapll_pkg::sapll_cfg_t      eep_cfg_o
);
    logic [7:0] cnt_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 8'h00;
            eep_done_o <= 1'b0;
        end else if (cnt_r != delay_i) begin
            cnt_r <= cnt_r + 8'h01;
        end else begin
            eep_done_o <= 1'b1;
        end
    end
    // Image is unknown until the read ends, so show a garbled one
    assign eep_cfg_o = eep_done_o ? image_i : ~image_i;
    assign eep_valid_o = eep_done_o & good_i;
endmodule // sapll_eep_model

// ==== dv/system_system_analog_pll_config_and_lock_status_tb_top.sv ====
`timescale 1ns/1ps
module system_system_analog_pll_config_and_lock_status_tb_top;
    import sapll_pkg::*;
    localparam int LOCK_N = 4;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;
    logic        otp_en = 1'b0;
    logic        otp_valid = 1'b0;
    logic        eep_en = 1'b0;
    logic        raw = 1'b0;
    logic [7:0]  eep_dly = 8'h10;
    logic [11:0] vctrl = 12'h000;
    sapll_cfg_t  otp_cfg = '0;
    sapll_cfg_t  eep_img = '0;
    sapll_cfg_t  eep_cfg, cfg;
    logic [31:0] rdata;
    logic        eep_valid, eep_done, dbl, done, locked, lol, gpio, irq, ok;
    logic [31:0] exp_q[$];
    logic [9:0]  fb;
    logic [9:0]  lim[5] = '{10'h079, 10'h07A, 10'h230, 10'h231, 10'h07A};
    int          fails = 0;
    int          checks = 0;

    sapll_top #(.LOCK_CYCLES(LOCK_N)) uut (
        .clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .otp_en_i(otp_en), .otp_valid_i(otp_valid), .otp_cfg_i(otp_cfg),
        .eep_en_i(eep_en), .eep_valid_i(eep_valid), .eep_done_i(eep_done), .eep_cfg_i(eep_cfg),
        .pll_lock_raw_i(raw), .vctrl_i(vctrl), .cfg_o(cfg), .ref_doubler_o(dbl),
        .cfg_done_o(done), .locked_o(locked), .lol_alarm_o(lol), .gpio_lol_o(gpio), .irq_o(irq));
    sapll_eep_model eep (.clk_i(clk), .resetn_i(resetn), .delay_i(eep_dly), .good_i(1'b1),
        .image_i(eep_img), .eep_valid_o(eep_valid), .eep_done_o(eep_done), .eep_cfg_o(eep_cfg));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [63:0] s, input logic [63:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic wait_for(input int sel, input logic val);
        for (int i = 0; i < 300; i++) begin
            @(negedge clk);
            if ((sel == 0 ? done : locked) === val)
                return;
        end
        fails++;
        $display("[FAIL] t=%0t wait ran out", $time);
        tally_and_finish();
    endtask
    task automatic do_reset(input logic oe, input logic ee);
        resetn <= 1'b0;
        otp_en <= oe;
        otp_valid <= oe;
        eep_en <= ee;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
    endtask
    function automatic sapll_cfg_t rnd_cfg();
        sapll_cfg_t c;
        // host keeps the divider legal; output divider fractions not modelled
        c.doubler = 1'($urandom);
        c.fbdiv = 10'(122 + $urandom % 439);
        c.freq_num = {16'($urandom), 32'($urandom)};
        c.freq_den = 16'($urandom % 65535 + 1);
        return c;
    endfunction

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d)
            check(rdata, exp_q.pop_front());
    end

    initial begin
        void'($urandom(32'h69b7));
        @(posedge clk);
        eep_img <= rnd_cfg();
        otp_cfg <= rnd_cfg();
        eep_dly <= 8'(10 + $urandom % 30);
        lim[4] = 10'(123 + $urandom % 436);
        do_reset(1'b0, 1'b1);
        bus_wr(SAPLL_REG_CTRL, 32'h3);
        wait_for(0, 1'b1);
        check(cfg.fbdiv, eep_img.fbdiv);
        check(dbl, eep_img.doubler);
        bus_rd(SAPLL_REG_FNUM_L, eep_img.freq_num[31:0]);
        bus_rd(SAPLL_REG_FNUM_H, {16'h0, eep_img.freq_num[47:32]});
        bus_rd(SAPLL_REG_FDEN, {16'h0, eep_img.freq_den});
        bus_rd(SAPLL_REG_STAT, 32'h16);
        bus_rd(SAPLL_REG_CTRL, {31'h0, eep_img.doubler});
        bus_rd(SAPLL_REG_IRQ_ST, 32'h8);
        bus_wr(SAPLL_REG_IRQ_ST, 32'hF);
        $display("test load done");
        fb = eep_img.fbdiv;
        foreach (lim[i]) begin
            bus_wr(SAPLL_REG_FBDIV, {22'h0, lim[i]});
            ok = lim[i] >= SAPLL_FBDIV_MIN && lim[i] <= SAPLL_FBDIV_MAX;
            if (ok)
                fb = lim[i];
            bus_rd(SAPLL_REG_STAT, {26'h0, !ok, 5'h16});
            bus_rd(SAPLL_REG_FBDIV, {22'h0, fb});
        end
        bus_rd(SAPLL_REG_IRQ_ST, 32'h4);
        bus_wr(SAPLL_REG_IRQ_MK, 32'h4);
        @(negedge clk);
        check(irq, 1'b1);
        bus_wr(SAPLL_REG_IRQ_MK, 32'h0);
        @(negedge clk);
        check(irq, 1'b0);
        bus_wr(SAPLL_REG_IRQ_ST, 32'h4);
        bus_rd(SAPLL_REG_IRQ_ST, 32'h0);
        $display("test divider done");
        bus_wr(SAPLL_REG_CTRL, 32'h3);
        @(negedge clk);
        check(dbl, 1'b1);
        @(posedge clk);
        vctrl <= 12'(2 * fb + 66);
        raw <= 1'b1;
        repeat (LOCK_N + 10) @(negedge clk);
        check(locked, 1'b0);
        @(posedge clk);
        vctrl <= 12'(2 * fb + 65);
        wait_for(1, 1'b1);
        check(lol, 1'b0);
        check(gpio, 1'b0);
        bus_rd(SAPLL_REG_STAT, 32'h15);
        @(posedge clk);
        raw <= 1'b0;
        wait_for(1, 1'b0);
        check(lol, 1'b1);
        check(gpio, 1'b1);
        bus_rd(SAPLL_REG_IRQ_ST, 32'h3);
        $display("test lock done");
        @(posedge clk);
        do_reset(1'b1, 1'b1);
        wait_for(0, 1'b1);
        check(cfg.freq_den, otp_cfg.freq_den);
        check(cfg.fbdiv, otp_cfg.fbdiv);
        bus_rd(SAPLL_REG_STAT, 32'h0E);
        bus_rd(SAPLL_REG_ID, SAPLL_ID_RST);
        bus_wr(8'h40, 32'hFFFF_FFFF);
        bus_rd(8'h40, 32'h0);
        repeat (2) @(posedge clk);
        $display("test reload done");
        tally_and_finish();
    end

    initial begin
        #2000000;
        fails++;
        tally_and_finish();
    end
endmodule // system_system_analog_pll_config_and_lock_status_tb_top
